//--- bus_watch_comparator_regs_tb.sv
// Testbench for the bus watch comparators: register port and match results.
// Assumes the processor bus model drives the watched bus.
module bus_watch_comparator_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bwc_pkg::*;
    logic mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, req = 0, rq_rd = 0, rq_ex = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, am, al;
    logic [17:0] bus_addr, rq_a = 0, ha;
    logic [15:0] bus_data, rq_d = 0;
    logic bus_read, bus_valid, opcode_exec, rd_pend = 0, v_pend = 0;
    logic [2:0] cmp_match;
    logic [7:0] rq[$];
    logic [2:0] mq[$];
    logic [2:0] tq[$];
    logic [2:0] tag_q;
    logic [2:0] exp_tag = 3'h0;
    int n_errors = 0, compares = 0;
    always #4 mclk = ~mclk;
    bwc_watch dut_u (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_addr(bus_addr),
        .bus_data(bus_data), .bus_read(bus_read), .bus_valid(bus_valid),
        .opcode_exec(opcode_exec), .cmp_match(cmp_match), .tag_request(tag_q));
    bwc_cpu_bus cpu_u (.mclk(mclk), .rstn(rstn), .req(req), .req_addr(rq_a), .req_data(rq_d),
        .req_read(rq_rd), .req_exec(rq_ex), .bus_addr(bus_addr), .bus_data(bus_data),
        .bus_read(bus_read), .bus_valid(bus_valid), .opcode_exec(opcode_exec));
    task automatic report_and_stop;
        if (n_errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge mclk) reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        rq.push_back(exp);
        @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge mclk) reg_rd <= 1'b0;
    endtask : rd
    task automatic bus(logic [17:0] a, logic [15:0] d, logic r, logic x, logic [2:0] exp);
        mq.push_back(exp);
        tq.push_back(exp_tag);
        @(posedge mclk) {req, rq_a, rq_d, rq_rd, rq_ex} <= {1'b1, a, d, r, x};
        @(posedge mclk) req <= 1'b0;
    endtask : bus
    // Results are taken mid-cycle, one cycle after each request was seen.
    always @(negedge mclk) begin
        if (rd_pend) chk("reg_rdata", reg_rdata, rq.pop_front());
        if (v_pend) chk("cmp_match", {5'h0, cmp_match}, {5'h0, mq.pop_front()});
        if (v_pend) chk("tag_request", {5'h0, tag_q}, {5'h0, tq.pop_front()});
        rd_pend = reg_rd;
        v_pend = bus_valid;
    end
    initial begin
        #200us;
        n_errors++;
        report_and_stop;
    end
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        void'($urandom(32'h6047));
        am = $urandom;
        al = $urandom;
        ha = {2'h3, am, al};
        for (int a = 8'h28; a <= 8'h2f; a++) rd(a[7:0], RESET_VAL);
        wr(OFF_ADDR_HIGH, 8'hff);
        wr(OFF_ADDR_MID, am);
        wr(OFF_ADDR_LOW, al);
        wr(OFF_DATA_HIGH, 8'h5a);
        rd(OFF_ADDR_HIGH, 8'h03);
        rd(OFF_ADDR_MID, am);
        rd(OFF_ADDR_LOW, al);
        rd(OFF_DATA_HIGH, 8'h5a);
        wr(OFF_UNIT_CTRL, 8'h01);
        wr(OFF_ADDR_LOW, ~al);
        wr(OFF_DATA_HIGH, 8'hff);
        rd(OFF_ADDR_LOW, ~al);
        rd(OFF_DATA_HIGH, 8'h00);
        wr(OFF_UNIT_CTRL, 8'h03);
        wr(OFF_ADDR_LOW, 8'h11);
        rd(OFF_ADDR_LOW, 8'h00);
        wr(OFF_UNIT_CTRL, 8'h80);
        wr(OFF_ADDR_LOW, ~al);
        wr(OFF_DATA_HIGH, 8'h00);
        rd(OFF_ADDR_LOW, al);
        rd(OFF_DATA_HIGH, 8'h5a);
        wr(OFF_UNIT_CTRL, 8'h81);
        rd(OFF_ADDR_LOW, ~al);
        wr(OFF_UNIT_CTRL, 8'h00);
        wr(OFF_MASK_HIGH, 8'hff);
        wr(OFF_CTRL, 8'h01);
        bus(ha, {8'h5a, 8'(~al)}, 1'b0, 1'b0, 3'b001);
        bus(ha, 16'h5b00, 1'b1, 1'b0, 3'b000);
        for (int k = 0; k < 18; k++) bus(ha ^ (18'h1 << k), 16'h5a00, 1'b1, 1'b0, 3'b000);
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CTRL, {4'h0, i[1], 3'h5});
            bus(ha, 16'h5a00, i[0], 1'b0, {2'b00, i[1] == i[0]});
        end
        wr(OFF_CTRL, 8'h03);
        bus(ha, 16'h5a00, 1'b1, 1'b0, 3'b000);
        bus(ha, 16'h5b00, 1'b1, 1'b0, 3'b001);
        wr(OFF_CTRL, 8'h2d);
        exp_tag = 3'b001;
        bus(ha, 16'h5b00, 1'b0, 1'b1, 3'b001);
        bus(ha, 16'h5b00, 1'b0, 1'b0, 3'b000);
        exp_tag = 3'b000;
        bus(ha ^ 18'h1, 16'h0000, 1'b0, 1'b1, 3'b001);
        wr(OFF_CTRL, 8'h00);
        bus(ha, 16'h5a00, 1'b1, 1'b0, 3'b000);
        wr(OFF_CTRL, 8'h01);
        wr(OFF_UNIT_CTRL, 8'h01);
        wr(OFF_ADDR_HIGH, 8'h03);
        wr(OFF_ADDR_MID, am);
        wr(OFF_ADDR_LOW, al);
        wr(OFF_CTRL, 8'h01);
        bus(ha, 16'h5b00, 1'b1, 1'b0, 3'b010);
        repeat (4) @(posedge mclk);
        if (rq.size() + mq.size() + tq.size() != 0) n_errors++;
        report_and_stop;
    end
endmodule : bus_watch_comparator_regs_tb

//--- bwc_cpu_bus.sv
// Processor bus model: one bus cycle per request, shown one clock later.
// Assumes requests change after a rising edge of mclk and last one cycle.
module bwc_cpu_bus (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Requests from the bench.
    input  wire logic        req,
    input  wire logic [17:0] req_addr,
    input  wire logic [15:0] req_data,
    input  wire logic        req_read,
    input  wire logic        req_exec,
    // Watched bus.
    output logic      [17:0] bus_addr,
    output logic      [15:0] bus_data,
    output logic             bus_read,
    output logic             bus_valid,
    output logic             opcode_exec
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle cycles show inverted values so that stale values never look valid.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            {bus_addr, bus_data, bus_read, bus_valid, opcode_exec} <= '0;
        end else begin
            bus_addr    <= req ? req_addr : ~bus_addr;
            bus_data    <= req ? req_data : ~bus_data;
            bus_read    <= req ? req_read : ~bus_read;
            bus_valid   <= req;
            opcode_exec <= req & req_exec;
        end
    end
endmodule : bwc_cpu_bus

//--- bwc_pkg.sv
// Package for the bus watch comparator registers.
// Assumes an 8-bit register port with byte offsets as listed here.
package bwc_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 8;
    localparam int          BUS_ADDR_W    = 18;
    localparam int          BUS_DATA_W    = 16;
    localparam int          NUM_CMP       = 3;
    // Register offsets inside the shared window.
    localparam logic [7:0]  OFF_CTRL      = 8'h28;
    localparam logic [7:0]  OFF_ADDR_HIGH = 8'h29;
    localparam logic [7:0]  OFF_ADDR_MID  = 8'h2a;
    localparam logic [7:0]  OFF_ADDR_LOW  = 8'h2b;
    localparam logic [7:0]  OFF_DATA_HIGH = 8'h2c;
    localparam logic [7:0]  OFF_DATA_LOW  = 8'h2d;
    localparam logic [7:0]  OFF_MASK_HIGH = 8'h2e;
    localparam logic [7:0]  OFF_MASK_LOW  = 8'h2f;
    // Unit control register holding view select and arm.
    localparam logic [7:0]  OFF_UNIT_CTRL = 8'h20;
    localparam int          UC_ARM_BIT    = 7;
    localparam int          UC_VIEW_LSB   = 0;
    // Comparator control field positions.
    localparam int          CT_TAG        = 5;
    localparam int          CT_RW         = 3;
    localparam int          CT_RWE        = 2;
    localparam int          CT_NDB        = 1;
    localparam int          CT_EN         = 0;
    localparam logic [7:0]  CTRL_A_MASK   = 8'h2f;
    localparam logic [7:0]  CTRL_BC_MASK  = 8'h2d;
    localparam logic [1:0]  ADDR_HIGH_MASK = 2'h3;
    localparam logic [7:0]  RESET_VAL     = 8'h00;
    localparam logic [1:0]  VIEW_A        = 2'h0;
    localparam logic [1:0]  VIEW_B        = 2'h1;
    localparam logic [1:0]  VIEW_C        = 2'h2;
    localparam logic [1:0]  VIEW_NONE     = 2'h3;
endpackage : bwc_pkg

//--- bwc_watch.sv
// Bus watch comparators: three address comparators, data compare on A only.
// Assumes register port and processor bus signals synchronous to mclk.
//
// Added by the designer: strobed register access.
module bwc_watch (
    // Clock and reset.
    input  wire logic                          mclk,
    input  wire logic                          rstn,
    // Register port.
    input  wire logic [bwc_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [bwc_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [bwc_pkg::DATA_W-1:0]    reg_rdata,
    // Processor bus being watched.
    input  wire logic [bwc_pkg::BUS_ADDR_W-1:0] bus_addr,
    input  wire logic [bwc_pkg::BUS_DATA_W-1:0] bus_data,
    input  wire logic                          bus_read,
    input  wire logic                          bus_valid,
    input  wire logic                          opcode_exec,
    // Match results, one bit per comparator.
    output logic      [bwc_pkg::NUM_CMP-1:0]   cmp_match,
    output logic      [bwc_pkg::NUM_CMP-1:0]   tag_request
);
    import bwc_pkg::*;

    function automatic logic bits_equal(input logic [BUS_ADDR_W-1:0] a,
                                        input logic [BUS_ADDR_W-1:0] b);
        bits_equal = (a == b);
    endfunction : bits_equal

    logic [7:0]  unit_ctrl;
    logic [7:0]  cmp_ctrl  [NUM_CMP];
    logic [1:0]  addr_high [NUM_CMP];
    logic [7:0]  addr_mid  [NUM_CMP];
    logic [7:0]  addr_low  [NUM_CMP];
    logic [15:0] data_val;
    logic [15:0] data_mask;
    logic [NUM_CMP-1:0] tag_pend;

    wire logic [1:0] view     = unit_ctrl[UC_VIEW_LSB +: 2];
    wire logic       armed    = unit_ctrl[UC_ARM_BIT];
    wire logic       view_ok  = (view != VIEW_NONE);
    wire logic [1:0] vidx     = (view == VIEW_NONE) ? 2'h0 : view;
    wire logic       wr_ok    = reg_wr && !armed && view_ok;
    wire logic       wr_a     = wr_ok && (view == VIEW_A);
    wire logic       wr_unit  = reg_wr && (reg_addr == OFF_UNIT_CTRL);
    wire logic [7:0] ctrl_msk = (view == VIEW_A) ? CTRL_A_MASK : CTRL_BC_MASK;

    // Read selection; hidden or missing registers read zero.
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = RESET_VAL;
        if (reg_addr == OFF_UNIT_CTRL) begin
            next_rdata = unit_ctrl;
        end else if (view_ok) begin
            case (reg_addr)
                OFF_CTRL:      next_rdata = cmp_ctrl[vidx];
                OFF_ADDR_HIGH: next_rdata = {6'h00, addr_high[vidx]};
                OFF_ADDR_MID:  next_rdata = addr_mid[vidx];
                OFF_ADDR_LOW:  next_rdata = addr_low[vidx];
                OFF_DATA_HIGH: next_rdata = (view == VIEW_A) ? data_val[15:8] : 8'h00;
                OFF_DATA_LOW:  next_rdata = (view == VIEW_A) ? data_val[7:0] : 8'h00;
                OFF_MASK_HIGH: next_rdata = (view == VIEW_A) ? data_mask[15:8] : 8'h00;
                OFF_MASK_LOW:  next_rdata = (view == VIEW_A) ? data_mask[7:0] : 8'h00;
                default:       next_rdata = RESET_VAL;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= RESET_VAL;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : RESET_VAL;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            unit_ctrl <= RESET_VAL;
        end else if (wr_unit) begin
            unit_ctrl <= reg_wdata & 8'h83;
        end
    end

    // Per-comparator registers; writes go to the visible one only.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_CMP; i++) begin
                cmp_ctrl[i]  <= RESET_VAL;
                addr_high[i] <= 2'h0;
                addr_mid[i]  <= RESET_VAL;
                addr_low[i]  <= RESET_VAL;
            end
        end else if (wr_ok) begin
            case (reg_addr)
                OFF_CTRL:      cmp_ctrl[vidx]  <= reg_wdata & ctrl_msk;
                OFF_ADDR_HIGH: addr_high[vidx] <= reg_wdata[1:0] & ADDR_HIGH_MASK;
                OFF_ADDR_MID:  addr_mid[vidx]  <= reg_wdata;
                OFF_ADDR_LOW:  addr_low[vidx]  <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            data_val  <= 16'h0000;
            data_mask <= 16'h0000;
        end else if (wr_a) begin
            case (reg_addr)
                OFF_DATA_HIGH: data_val[15:8]  <= reg_wdata;
                OFF_DATA_LOW:  data_val[7:0]   <= reg_wdata;
                OFF_MASK_HIGH: data_mask[15:8] <= reg_wdata;
                OFF_MASK_LOW:  data_mask[7:0]  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Match evaluation.
    logic [NUM_CMP-1:0] raw_hit;
    logic [NUM_CMP-1:0] next_match;
    logic [NUM_CMP-1:0] next_tag;
    wire logic [15:0] diff    = (bus_data ^ data_val) & data_mask;
    wire logic        data_eq = (diff == 16'h0000);
    wire logic        data_ok = cmp_ctrl[0][CT_NDB] ? !data_eq : data_eq;
    always_comb begin
        logic dir_ok;
        logic addr_ok;
        dir_ok  = 1'b0;
        addr_ok = 1'b0;
        for (int i = 0; i < NUM_CMP; i++) begin
            dir_ok  = !cmp_ctrl[i][CT_RWE] || (cmp_ctrl[i][CT_RW] == bus_read);
            addr_ok = bits_equal(bus_addr, {addr_high[i], addr_mid[i], addr_low[i]});
            raw_hit[i] = bus_valid && cmp_ctrl[i][CT_EN] && addr_ok;
            if (cmp_ctrl[i][CT_TAG]) begin
                next_tag[i]   = raw_hit[i];
                next_match[i] = (tag_pend[i] || raw_hit[i]) && opcode_exec && cmp_ctrl[i][CT_EN];
            end else begin
                next_tag[i]   = 1'b0;
                next_match[i] = raw_hit[i] && dir_ok && ((i != 0) || data_ok);
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tag_pend    <= '0;
            cmp_match   <= '0;
            tag_request <= '0;
        end else begin
            tag_pend    <= (tag_pend | next_tag) & ~(next_match | ~{cmp_ctrl[2][CT_TAG],
                           cmp_ctrl[1][CT_TAG], cmp_ctrl[0][CT_TAG]});
            cmp_match   <= next_match;
            tag_request <= next_tag;
        end
    end

    dis_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_wr && armed && reg_addr == OFF_ADDR_LOW) |=> $stable(addr_low[vidx]))
        else $error("Address written while armed.");
    none_view_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_rd && view == VIEW_NONE && reg_addr != OFF_UNIT_CTRL) |=> reg_rdata == 8'h00)
        else $error("Hidden view read nonzero.");
    data_hide_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_rd && view == VIEW_B && reg_addr == OFF_DATA_HIGH) |=> reg_rdata == 8'h00)
        else $error("Comparator B data read nonzero.");
    high_bits_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_rd && reg_addr == OFF_ADDR_HIGH) |=> reg_rdata[7:2] == 6'h00)
        else $error("Address high upper bits nonzero.");
    enable_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
        (!cmp_ctrl[1][CT_EN]) |=> !cmp_match[1])
        else $error("Disabled comparator matched.");
    dir_qual_a: assert property (@(posedge mclk) disable iff (!rstn)
        (!cmp_ctrl[2][CT_TAG] && cmp_ctrl[2][CT_RWE] && cmp_ctrl[2][CT_RW] != bus_read)
        |=> !cmp_match[2])
        else $error("Direction mismatch matched.");
    addr_qual_a: assert property (@(posedge mclk) disable iff (!rstn)
        (bus_addr[7:0] != addr_low[1]) |=> !cmp_match[1] || $past(cmp_ctrl[1][CT_TAG]))
        else $error("Address mismatch matched.");
    data_qual_a: assert property (@(posedge mclk) disable iff (!rstn)
        (!cmp_ctrl[0][CT_TAG] && !cmp_ctrl[0][CT_NDB] && diff != 16'h0000) |=> !cmp_match[0])
        else $error("Masked data mismatch matched.");
    read_lat_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_rd && view == VIEW_A && reg_addr == OFF_ADDR_MID) |=> reg_rdata == $past(addr_mid[0]))
        else $error("Address mid read wrong.");

    // Building blocks for the write lock and tag mode checks.
    // A register write while the unit is armed.
    sequence arm_wr_s;
        reg_wr && armed;
    endsequence

    // An address hit on comparator A in tag mode.
    sequence tag_hit_s;
        cmp_ctrl[0][CT_TAG] && raw_hit[0];
    endsequence

    // A tagged opcode executing with a pending tag on comparator A.
    sequence pend_exec_s;
        tag_pend[0] && cmp_ctrl[0][CT_TAG] && cmp_ctrl[0][CT_EN] && opcode_exec;
    endsequence

    // A tagged opcode executing in the same cycle as its address hit.
    sequence hit_exec_s;
        raw_hit[0] && cmp_ctrl[0][CT_TAG] && opcode_exec;
    endsequence

    // Control writes are dropped while armed.
    ctrl_lock_a: assert property (@(posedge mclk) disable iff (!rstn)
        arm_wr_s ##0 (reg_addr == OFF_CTRL)
        |=> $stable(cmp_ctrl[vidx]))
        else $error("Control written while armed.");

    // Address mid writes are dropped while armed.
    mid_lock_a: assert property (@(posedge mclk) disable iff (!rstn)
        arm_wr_s ##0 (reg_addr == OFF_ADDR_MID)
        |=> $stable(addr_mid[vidx]))
        else $error("Address mid written while armed.");

    // A full address hit on comparator B, outside tag mode, with no direction check gives a match.
    full_match_a: assert property (@(posedge mclk) disable iff (!rstn)
        (raw_hit[1] && !cmp_ctrl[1][CT_TAG] && !cmp_ctrl[1][CT_RWE])
        |=> cmp_match[1])
        else $error("Address hit gave no match.");

    // Data high writes are dropped while armed.
    data_lock_a: assert property (@(posedge mclk) disable iff (!rstn)
        arm_wr_s ##0 (reg_addr == OFF_DATA_HIGH)
        |=> $stable(data_val))
        else $error("Data written while armed.");

    // Data and mask registers change only under view A.
    data_view_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_wr && view != VIEW_A)
        |=> $stable(data_val) && $stable(data_mask))
        else $error("Data written outside view A.");

    // Data high reads as zero outside view A.
    data_rdhide_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_rd && view != VIEW_A && reg_addr == OFF_DATA_HIGH)
        |=> reg_rdata == 8'h00)
        else $error("Data high visible outside view A.");

    // Read data is zero when no read was made.
    rdata_idle_a: assert property (@(posedge mclk) disable iff (!rstn)
        (!reg_rd)
        |=> reg_rdata == 8'h00)
        else $error("Read data without a read.");

    // An unarmed address mid write lands in comparator A.
    mid_store_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_wr && !armed && view == VIEW_A && reg_addr == OFF_ADDR_MID)
        |=> addr_mid[0] == $past(reg_wdata))
        else $error("Address mid write lost.");

    // An unarmed address low write lands in comparator B.
    low_store_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_wr && !armed && view == VIEW_B && reg_addr == OFF_ADDR_LOW)
        |=> addr_low[1] == $past(reg_wdata))
        else $error("Address low write lost.");

    // An unarmed address high write keeps its two low bits.
    high_store_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_wr && !armed && view == VIEW_A && reg_addr == OFF_ADDR_HIGH)
        |=> addr_high[0] == $past(reg_wdata[1:0]))
        else $error("Address high write lost.");

    // An unarmed data high write lands in the upper data byte.
    data_store_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_wr && !armed && view == VIEW_A && reg_addr == OFF_DATA_HIGH)
        |=> data_val[15:8] == $past(reg_wdata))
        else $error("Data high write lost.");

    // With no comparator visible, address writes go nowhere.
    none_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_wr && view == VIEW_NONE && reg_addr == OFF_ADDR_LOW)
        |=> $stable(addr_low[0]) && $stable(addr_low[1]) && $stable(addr_low[2]))
        else $error("Hidden view written.");

    // The view select field follows a unit control write.
    unit_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_wr && reg_addr == OFF_UNIT_CTRL)
        |=> unit_ctrl == ($past(reg_wdata) & 8'h83))
        else $error("Unit control write lost.");

    // Comparator B has no mismatch select.
    ctrl_b_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_wr && !armed && view == VIEW_B && reg_addr == OFF_CTRL)
        |=> !cmp_ctrl[1][CT_NDB])
        else $error("Comparator B took a data bit.");

    // A tag mode hit raises the tag request.
    tag_set_a: assert property (@(posedge mclk) disable iff (!rstn)
        tag_hit_s
        |=> tag_request[0])
        else $error("Tag hit not requested.");

    // A pending tag fires when its opcode executes.
    tag_fire_a: assert property (@(posedge mclk) disable iff (!rstn)
        pend_exec_s
        |=> cmp_match[0])
        else $error("Pending tag did not fire.");

    // In tag mode the data compare takes no part.
    tag_data_a: assert property (@(posedge mclk) disable iff (!rstn)
        hit_exec_s
        |=> cmp_match[0])
        else $error("Tag match blocked by data.");

    // Leaving tag mode drops a pending tag.
    tag_drop_a: assert property (@(posedge mclk) disable iff (!rstn)
        (tag_pend[0] && !cmp_ctrl[0][CT_TAG])
        |=> !tag_pend[0])
        else $error("Stale tag kept.");

    // Mismatch select matches on a masked data difference.
    ndb_match_a: assert property (@(posedge mclk) disable iff (!rstn)
        (raw_hit[0] && !cmp_ctrl[0][CT_TAG] && !cmp_ctrl[0][CT_RWE] && cmp_ctrl[0][CT_NDB]
        && diff != 16'h0000)
        |=> cmp_match[0])
        else $error("Data difference gave no match.");

endmodule : bwc_watch
